// >>> cfc_pkg.sv
// Shared constants, operation codes and decoders for the execution core.
// Assumes one 100 MHz clock and an issuing stage that drives one op at a time.
package cfc_pkg;

	// ==========================================
	// Geometry
	localparam int CFC_REG_COUNT = 32;
	localparam int CFC_STACK_DEPTH = 16;
	localparam logic [4:0] CFC_PROD_LO = 5'h00;
	localparam logic [4:0] CFC_PROD_HI = 5'h01;
	localparam logic [4:0] CFC_PAIR_BIT = 5'h01;
	localparam logic [4:0] CFC_ZPTR_LO = 5'h1e;
	localparam logic [4:0] CFC_ZPTR_HI = 5'h1f;
	localparam int CFC_WORD_K_MSB = 5;
	localparam logic [7:0] CFC_BYTE_ONES = 8'hff;

	// ==========================================
	// Reset values and steps
	localparam logic [15:0] CFC_PC_RESET = 16'h0000;
	localparam logic [15:0] CFC_PC_ONE = 16'h0001;
	localparam logic [15:0] CFC_PC_TWO = 16'h0002;
	localparam logic [7:0] CFC_SREG_RESET = 8'h00;
	localparam logic [3:0] CFC_SP_RESET = 4'hf;
	localparam logic [3:0] CFC_SP_ONE = 4'h1;

	// ==========================================
	// Status bit positions
	localparam int CFC_FLAG_C = 0;
	localparam int CFC_FLAG_Z = 1;
	localparam int CFC_FLAG_N = 2;
	localparam int CFC_FLAG_V = 3;
	localparam int CFC_FLAG_S = 4;
	localparam int CFC_FLAG_H = 5;
	localparam int CFC_FLAG_I = 7;

	// ==========================================
	// Clock counts
	localparam logic [2:0] CFC_CLK_ONE = 3'h1;
	localparam logic [2:0] CFC_CLK_TWO = 3'h2;
	localparam logic [2:0] CFC_CLK_THREE = 3'h3;
	localparam logic [2:0] CFC_CLK_FOUR = 3'h4;

	typedef enum logic [4:0] {
		op_add_registers, op_add_with_carry, op_word_add_immediate,
		op_subtract_registers, op_subtract_constant,
		op_subtract_with_borrow, op_subtract_constant_with_borrow,
		op_word_subtract_immediate, op_conjunction,
		op_conjunction_with_constant, op_disjunction,
		op_disjunction_with_constant, op_exclusive_disjunction,
		op_set_mask_bits, op_clear_mask_bits, op_zero_minus_test,
		op_unsigned_product, op_signed_product, op_mixed_sign_product,
		op_fractional_unsigned_product, op_fractional_signed_product,
		op_fractional_mixed_product, op_relative_jump, op_relative_call,
		op_indirect_jump, op_indirect_call, op_direct_jump,
		op_direct_call, op_subroutine_return, op_interrupt_return
	} cfc_op_type;

	function automatic logic cfc_is_product(input cfc_op_type op);
		return op inside {op_unsigned_product, op_signed_product,
			op_mixed_sign_product, op_fractional_unsigned_product,
			op_fractional_signed_product, op_fractional_mixed_product};
	endfunction : cfc_is_product

	function automatic logic cfc_is_push(input cfc_op_type op);
		return op inside {op_relative_call, op_indirect_call,
			op_direct_call};
	endfunction : cfc_is_push

	function automatic logic [2:0] cfc_op_clocks(input cfc_op_type op);
		if (cfc_is_product(op) || op inside {op_word_add_immediate,
			op_word_subtract_immediate, op_relative_jump, op_indirect_jump})
			return CFC_CLK_TWO;
		if (op inside {op_relative_call, op_indirect_call, op_direct_jump})
			return CFC_CLK_THREE;
		if (op inside {op_direct_call, op_subroutine_return,
			op_interrupt_return})
			return CFC_CLK_FOUR;
		return CFC_CLK_ONE;
	endfunction : cfc_op_clocks

endpackage : cfc_pkg

// >>> cfc_ex_if.sv
// Operand and result bundle between the core and its arithmetic unit.
// Assumes the core drives operands from its register file each cycle.
`timescale 1ns/1ns
`default_nettype none
interface cfc_ex_if;
	import cfc_pkg::*;
	cfc_op_type op;
	logic [7:0] a;
	logic [7:0] b;
	logic [7:0] k;
	logic [15:0] word_in;
	logic [7:0] sreg_in;
	logic [7:0] res_lo;
	logic [7:0] res_hi;
	logic [7:0] sreg_out;
	logic wr_lo;
	logic wr_hi;
	modport core (output op, a, b, k, word_in, sreg_in,
		input res_lo, res_hi, sreg_out, wr_lo, wr_hi);
	modport alu (input op, a, b, k, word_in, sreg_in,
		output res_lo, res_hi, sreg_out, wr_lo, wr_hi);
endinterface : cfc_ex_if
`default_nettype wire

// >>> cfc_alu.sv
// Combinational arithmetic, logic and product unit with flag updates.
// Assumes the core commits its results only in the op's last clock.
`timescale 1ns/1ns
`default_nettype none
module cfc_alu import cfc_pkg::*; (
	cfc_ex_if.alu ex
);
	logic [8:0] sum9;
	logic [16:0] word17;
	logic signed [8:0] fa;
	logic signed [8:0] fb;
	logic signed [17:0] prod;
	logic [15:0] raw;
	logic [15:0] w;
	logic [7:0] opb;
	logic [7:0] r;
	logic cin;
	logic logic_op;

	// ==========================================
	// Datapath
	always_comb begin
		sum9 = '0;
		word17 = '0;
		fa = '0;
		fb = '0;
		prod = '0;
		raw = '0;
		w = '0;
		r = '0;
		cin = 1'b0;
		logic_op = 1'b0;
		opb = ex.b;
		ex.res_lo = ex.a;
		ex.res_hi = ex.word_in[15:8];
		ex.sreg_out = ex.sreg_in;
		ex.wr_lo = 1'b0;
		ex.wr_hi = 1'b0;
		case (ex.op)
			op_add_registers, op_add_with_carry: begin
				cin = (ex.op == op_add_with_carry) & ex.sreg_in[CFC_FLAG_C];
				sum9 = {1'b0, ex.a} + {1'b0, ex.b} + {8'h00, cin};
				r = sum9[7:0];
				ex.res_lo = r;
				ex.wr_lo = 1'b1;
				ex.sreg_out[CFC_FLAG_C] = sum9[8];
				ex.sreg_out[CFC_FLAG_Z] = (r == 8'h00);
				ex.sreg_out[CFC_FLAG_N] = r[7];
				ex.sreg_out[CFC_FLAG_V] = (ex.a[7] & ex.b[7] & ~r[7]) |
					(~ex.a[7] & ~ex.b[7] & r[7]);
				ex.sreg_out[CFC_FLAG_H] = (ex.a[3] & ex.b[3]) |
					(ex.b[3] & ~r[3]) | (~r[3] & ex.a[3]);
			end
			op_subtract_registers, op_subtract_constant,
			op_subtract_with_borrow, op_subtract_constant_with_borrow: begin
				if (ex.op inside {op_subtract_constant,
					op_subtract_constant_with_borrow})
					opb = ex.k;
				cin = (ex.op inside {op_subtract_with_borrow,
					op_subtract_constant_with_borrow}) & ex.sreg_in[CFC_FLAG_C];
				sum9 = {1'b0, ex.a} - {1'b0, opb} - {8'h00, cin};
				r = sum9[7:0];
				ex.res_lo = r;
				ex.wr_lo = 1'b1;
				ex.sreg_out[CFC_FLAG_C] = sum9[8];
				ex.sreg_out[CFC_FLAG_Z] = (r == 8'h00);
				ex.sreg_out[CFC_FLAG_N] = r[7];
				ex.sreg_out[CFC_FLAG_V] = (ex.a[7] & ~opb[7] & ~r[7]) |
					(~ex.a[7] & opb[7] & r[7]);
				ex.sreg_out[CFC_FLAG_H] = (~ex.a[3] & opb[3]) |
					(opb[3] & r[3]) | (r[3] & ~ex.a[3]);
			end
			op_word_add_immediate, op_word_subtract_immediate: begin
				// Constant is six bits wide, as the pair op encodes it
				if (ex.op == op_word_add_immediate)
					word17 = {1'b0, ex.word_in} +
						{11'h000, ex.k[CFC_WORD_K_MSB:0]};
				else
					word17 = {1'b0, ex.word_in} -
						{11'h000, ex.k[CFC_WORD_K_MSB:0]};
				w = word17[15:0];
				ex.res_lo = w[7:0];
				ex.res_hi = w[15:8];
				ex.wr_lo = 1'b1;
				ex.wr_hi = 1'b1;
				ex.sreg_out[CFC_FLAG_C] = word17[16];
				ex.sreg_out[CFC_FLAG_Z] = (w == 16'h0000);
				ex.sreg_out[CFC_FLAG_N] = w[15];
				ex.sreg_out[CFC_FLAG_V] = (ex.op == op_word_add_immediate) ?
					(~ex.word_in[15] & w[15]) : (ex.word_in[15] & ~w[15]);
				ex.sreg_out[CFC_FLAG_S] = w[15] ^
					ex.sreg_out[CFC_FLAG_V];
			end
			op_conjunction: begin
				r = ex.a & ex.b;
				logic_op = 1'b1;
			end
			op_conjunction_with_constant: begin
				r = ex.a & ex.k;
				logic_op = 1'b1;
			end
			op_disjunction: begin
				r = ex.a | ex.b;
				logic_op = 1'b1;
			end
			op_disjunction_with_constant, op_set_mask_bits: begin
				r = ex.a | ex.k;
				logic_op = 1'b1;
			end
			op_exclusive_disjunction: begin
				r = ex.a ^ ex.b;
				logic_op = 1'b1;
			end
			op_clear_mask_bits: begin
				r = ex.a & (CFC_BYTE_ONES - ex.k);
				logic_op = 1'b1;
			end
			op_zero_minus_test: begin
				r = ex.a & ex.a;
				logic_op = 1'b1;
			end
			op_unsigned_product, op_signed_product, op_mixed_sign_product,
			op_fractional_unsigned_product, op_fractional_signed_product,
			op_fractional_mixed_product: begin
				fa = (ex.op inside {op_unsigned_product,
					op_fractional_unsigned_product}) ?
					$signed({1'b0, ex.a}) : $signed({ex.a[7], ex.a});
				fb = (ex.op inside {op_signed_product,
					op_fractional_signed_product}) ?
					$signed({ex.b[7], ex.b}) : $signed({1'b0, ex.b});
				prod = fa * fb;
				raw = prod[15:0];
				// Carry keeps the top bit lost by the fractional shift
				if (ex.op inside {op_fractional_unsigned_product,
					op_fractional_signed_product, op_fractional_mixed_product})
					w = {raw[14:0], 1'b0};
				else
					w = raw;
				ex.res_lo = w[7:0];
				ex.res_hi = w[15:8];
				ex.wr_lo = 1'b1;
				ex.wr_hi = 1'b1;
				ex.sreg_out[CFC_FLAG_C] = raw[15];
				ex.sreg_out[CFC_FLAG_Z] = (w == 16'h0000);
			end
			default: begin
			end
		endcase
		if (logic_op) begin
			ex.res_lo = r;
			ex.wr_lo = 1'b1;
			ex.sreg_out[CFC_FLAG_Z] = (r == 8'h00);
			ex.sreg_out[CFC_FLAG_N] = r[7];
			ex.sreg_out[CFC_FLAG_V] = 1'b0;
		end
	end

endmodule : cfc_alu
`default_nettype wire

// >>> cfc_seq.sv
// Clock-count sequencer: holds an op for its documented number of clocks.
// Assumes the op length is sampled only on the accepting edge.
`timescale 1ns/1ns
`default_nettype none
module cfc_seq import cfc_pkg::*; (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire logic [2:0] len_i,
	output logic busy_o,
	output logic last_o
);
	logic [2:0] remain_ff;
	logic busy_ff;

	// ==========================================
	// Countdown
	assign busy_o = busy_ff;
	assign last_o = (start_i & ~busy_ff & (len_i == CFC_CLK_ONE)) |
		(busy_ff & (remain_ff == CFC_CLK_ONE));

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			remain_ff <= 3'h0;
			busy_ff <= 1'b0;
		end else if (start_i && !busy_ff) begin
			remain_ff <= len_i - CFC_CLK_ONE;
			busy_ff <= (len_i != CFC_CLK_ONE);
		end else if (busy_ff) begin
			remain_ff <= remain_ff - CFC_CLK_ONE;
			busy_ff <= (remain_ff != CFC_CLK_ONE);
		end
	end

	chk_four_clock_span: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(start_i && !busy_ff && len_i == CFC_CLK_FOUR) |=>
		busy_o [*3] ##1 !busy_o)
		else $error("four clock op did not span four clocks");

endmodule : cfc_seq
`default_nettype wire

// >>> cfc_core.sv
// Execution core: register file, status, program counter and return stack.
// Assumes the issuing stage decodes ops and holds start until busy drops.
//
// Operation
// - Add registers, optional carry in; sets Z C N V H; one clock.
// - Add six-bit constant to register pair; sets Z C N V S; two clocks.
// - Subtract registers, optional borrow; sets Z C N V H; one clock.
// - Subtract constant, optional borrow; sets Z C N V H; one clock.
// - Subtract constant from register pair; sets Z C N V S; two clocks.
// - AND with register or constant; sets Z N, clears V; one clock.
// - OR with register or constant, XOR registers; Z N V; one clock.
// - Set mask ORs constant; clear mask ANDs its complement; one clock.
// - Zero or minus test leaves register, updates Z N V; one clock.
// - Products of all three signednesses land in pair one:zero; Z C; two.
// - Fractional products shift left one first; Z C; two clocks.
// - Relative jump and call go to pc plus offset plus one; 2 and 3.
// - Indirect jump loads pc from pointer pair; flags kept; two clocks.
// - Indirect call pushes return and loads pointer pair; three clocks.
`timescale 1ns/1ns
`default_nettype none
module cfc_core import cfc_pkg::*; (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire cfc_op_type op_i,
	input wire logic [4:0] dst_i,
	input wire logic [4:0] src_i,
	input wire logic [7:0] imm_i,
	input wire logic [11:0] offset_i,
	input wire logic [15:0] target_i,
	input wire logic [4:0] rd_addr_i,
	output logic [15:0] pc_o,
	output logic [7:0] sreg_o,
	output logic [3:0] sp_o,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] rd_data_o
);
	logic [7:0] regs_ff [CFC_REG_COUNT];
	logic [15:0] stack_ff [CFC_STACK_DEPTH];
	logic [7:0] sreg_ff;
	logic [15:0] pc_ff;
	logic [3:0] sp_ff;
	logic done_ff;
	logic [7:0] rd_data_ff;
	cfc_op_type op_ff;
	logic [4:0] dst_ff;
	logic [4:0] src_ff;
	logic [7:0] imm_ff;
	logic [11:0] off_ff;
	logic [15:0] tgt_ff;
	logic busy;
	logic commit;
	logic start_ok;
	cfc_op_type cur_op;
	logic [4:0] cur_dst;
	logic [4:0] cur_src;
	logic [7:0] cur_imm;
	logic [11:0] cur_off;
	logic [15:0] cur_tgt;
	logic [4:0] lo_idx;
	logic [4:0] hi_idx;
	logic [15:0] z_ptr;
	logic [15:0] rel_target;
	logic [15:0] return_addr;
	logic [15:0] pop_addr;
	logic [7:0] nxt_sreg;
	logic [7:0] add_ref;
	logic [7:0] sub_ref;
	logic sub_borrow;
	logic carry_q;

	cfc_ex_if ex ();

	cfc_alu u_alu (
		.ex(ex)
	);

	cfc_seq u_seq (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.start_i(start_i),
		.len_i(cfc_op_clocks(op_i)),
		.busy_o(busy),
		.last_o(commit)
	);

	// ==========================================
	// Operand selection
	// Ops arriving while busy are dropped; issuer must wait for busy low
	assign start_ok = start_i & ~busy;
	assign cur_op = busy ? op_ff : op_i;
	assign cur_dst = busy ? dst_ff : dst_i;
	assign cur_src = busy ? src_ff : src_i;
	assign cur_imm = busy ? imm_ff : imm_i;
	assign cur_off = busy ? off_ff : offset_i;
	assign cur_tgt = busy ? tgt_ff : target_i;

	assign ex.op = cur_op;
	assign ex.a = regs_ff[cur_dst];
	assign ex.b = regs_ff[cur_src];
	assign ex.k = cur_imm;
	assign ex.word_in = {regs_ff[cur_dst | CFC_PAIR_BIT], regs_ff[cur_dst]};
	assign ex.sreg_in = sreg_ff;

	assign lo_idx = cfc_is_product(cur_op) ? CFC_PROD_LO : cur_dst;
	assign hi_idx = cfc_is_product(cur_op) ? CFC_PROD_HI :
		(cur_dst | CFC_PAIR_BIT);

	assign z_ptr = {regs_ff[CFC_ZPTR_HI], regs_ff[CFC_ZPTR_LO]};
	assign rel_target = pc_ff + {{4{cur_off[11]}}, cur_off} + CFC_PC_ONE;
	assign return_addr = pc_ff + ((cur_op == op_direct_call) ?
		CFC_PC_TWO : CFC_PC_ONE);
	assign pop_addr = stack_ff[4'(sp_ff + CFC_SP_ONE)];

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			op_ff <= op_add_registers;
			dst_ff <= 5'h00;
			src_ff <= 5'h00;
			imm_ff <= 8'h00;
			off_ff <= 12'h000;
			tgt_ff <= 16'h0000;
		end else if (start_ok) begin
			op_ff <= op_i;
			dst_ff <= dst_i;
			src_ff <= src_i;
			imm_ff <= imm_i;
			off_ff <= offset_i;
			tgt_ff <= target_i;
		end
	end

	// ==========================================
	// Register file
	for (genvar g = 0; g < CFC_REG_COUNT; g++) begin : g_reg
		always_ff @(posedge core_clk_i or posedge reset_i) begin
			if (reset_i)
				regs_ff[g] <= 8'h00;
			else if (commit && ex.wr_lo && lo_idx == 5'(g))
				regs_ff[g] <= ex.res_lo;
			else if (commit && ex.wr_hi && hi_idx == 5'(g))
				regs_ff[g] <= ex.res_hi;
		end
	end

	// ==========================================
	// Status register
	// Flow ops pass the status through untouched, except the I bit
	always_comb begin
		nxt_sreg = ex.sreg_out;
		if (cur_op == op_interrupt_return)
			nxt_sreg[CFC_FLAG_I] = 1'b1;
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			sreg_ff <= CFC_SREG_RESET;
		else if (commit)
			sreg_ff <= nxt_sreg;
	end

	// ==========================================
	// Program counter and return stack
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			pc_ff <= CFC_PC_RESET;
		else if (commit) begin
			case (cur_op)
				op_relative_jump, op_relative_call:
					pc_ff <= rel_target;
				op_indirect_jump, op_indirect_call:
					pc_ff <= z_ptr;
				op_direct_jump, op_direct_call:
					pc_ff <= cur_tgt;
				op_subroutine_return, op_interrupt_return:
					pc_ff <= pop_addr;
				default:
					pc_ff <= pc_ff + CFC_PC_ONE;
			endcase
		end
	end

	// Stack wraps silently; depth is fixed, overflow is the caller's care
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			sp_ff <= CFC_SP_RESET;
		else if (commit && cfc_is_push(cur_op))
			sp_ff <= sp_ff - CFC_SP_ONE;
		else if (commit && cur_op inside {op_subroutine_return,
			op_interrupt_return})
			sp_ff <= sp_ff + CFC_SP_ONE;
	end

	always_ff @(posedge core_clk_i) begin
		if (commit && cfc_is_push(cur_op))
			stack_ff[sp_ff] <= return_addr;
	end

	// ==========================================
	// Outputs
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			done_ff <= 1'b0;
			rd_data_ff <= 8'h00;
		end else begin
			done_ff <= commit;
			rd_data_ff <= regs_ff[rd_addr_i];
		end
	end

	assign pc_o = pc_ff;
	assign sreg_o = sreg_ff;
	assign sp_o = sp_ff;
	assign busy_o = busy;
	assign done_o = done_ff;
	assign rd_data_o = rd_data_ff;

	// ==========================================
	// Checks
	assign add_ref = ex.a + ex.b +
		{7'h00, (cur_op == op_add_with_carry) & sreg_ff[CFC_FLAG_C]};
	assign sub_ref = ex.a - ex.k;
	assign sub_borrow = ex.a < ex.b;
	assign carry_q = sreg_ff[CFC_FLAG_C];

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	chk_add_one_clock: assert property (
		(start_ok && op_i inside {op_add_registers, op_add_with_carry}) |->
		commit ##1 regs_ff[$past(cur_dst)] == $past(add_ref))
		else $error("register add wrong or late");

	chk_word_add_two: assert property (
		(start_ok && op_i == op_word_add_immediate) |->
		!commit ##1 commit ##1 done_o)
		else $error("word add not two clocks");

	chk_sub_borrow_flag: assert property (
		(commit && cur_op == op_subtract_registers) |=>
		carry_q == $past(sub_borrow))
		else $error("subtract borrow flag wrong");

	chk_const_sub_value: assert property (
		(commit && cur_op == op_subtract_constant) |=>
		regs_ff[$past(cur_dst)] == $past(sub_ref))
		else $error("constant subtract result wrong");

	chk_word_sub_two: assert property (
		(start_ok && op_i == op_word_subtract_immediate) |=>
		busy_o && commit ##1 !busy_o)
		else $error("word subtract not two clocks");

	chk_logic_keeps_carry: assert property (
		(commit && cur_op inside {op_conjunction, op_disjunction,
		op_exclusive_disjunction}) |=>
		!sreg_ff[CFC_FLAG_V] && carry_q == $past(carry_q))
		else $error("logic op flags wrong");

	chk_clear_mask_value: assert property (
		(commit && cur_op == op_clear_mask_bits) |=>
		regs_ff[$past(cur_dst)] == ($past(ex.a) & ~$past(ex.k)))
		else $error("clear mask result wrong");

	chk_test_keeps_reg: assert property (
		(commit && cur_op == op_zero_minus_test) |=>
		regs_ff[$past(cur_dst)] == $past(ex.a) &&
		sreg_ff[CFC_FLAG_Z] == ($past(ex.a) == 8'h00))
		else $error("test altered register or zero flag wrong");

	chk_product_two: assert property (
		(start_ok && cfc_is_product(op_i)) |-> ##1 commit)
		else $error("product not two clocks");

	chk_rel_jump_target: assert property (
		(commit && cur_op == op_relative_jump) |=>
		pc_ff == $past(rel_target) && sreg_ff == $past(sreg_ff))
		else $error("relative jump target or flags wrong");

	chk_ind_jump_target: assert property (
		(start_ok && op_i == op_indirect_jump) |->
		##1 commit ##1 pc_ff == $past(z_ptr))
		else $error("indirect jump wrong");

	chk_ind_call_push: assert property (
		(start_ok && op_i == op_indirect_call) |->
		!commit ##1 !commit ##1 commit ##1
		(pc_ff == $past(z_ptr) && sp_ff == $past(sp_ff) - CFC_SP_ONE))
		else $error("indirect call wrong");

	chk_return_gie: assert property (
		(commit && cur_op == op_interrupt_return) |=>
		sreg_ff[CFC_FLAG_I] && pc_ff == $past(pop_addr))
		else $error("interrupt return wrong");

endmodule : cfc_core
`default_nettype wire

// >>> cfc_core_tb.sv
// Self-checking bench for the execution core: arithmetic, products, flow.
// Assumes registers are loaded only through the core's own mask operations.
`timescale 1ns/1ns
`default_nettype none
module cfc_core_tb import cfc_pkg::*;;
	// ==========================================
	// Stimulus and observed signals
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic start_i = 1'b0;
	cfc_op_type op_i = op_add_registers;
	logic [4:0] dst_i = 5'h00;
	logic [4:0] src_i = 5'h00;
	logic [7:0] imm_i = 8'h00;
	logic [11:0] offset_i = 12'h000;
	logic [15:0] target_i = 16'h0000;
	logic [4:0] rd_addr_i = 5'h00;
	logic [15:0] pc_o;
	logic [7:0] sreg_o;
	logic [3:0] sp_o;
	logic busy_o;
	logic done_o;
	logic [7:0] rd_data_o;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	logic [15:0] epc = 16'h0000;
	cfc_op_type pops [6] = '{op_unsigned_product, op_signed_product,
		op_mixed_sign_product, op_fractional_unsigned_product,
		op_fractional_signed_product, op_fractional_mixed_product};
	logic [15:0] pexp [6] = '{16'h0100, 16'hff00, 16'hff00, 16'h0200,
		16'hfe00, 16'hfe00};
	logic [7:0] pfl [6] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01};

	always #5 core_clk_i = ~core_clk_i;

	cfc_core i_cfc_core (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.start_i(start_i), .op_i(op_i), .dst_i(dst_i), .src_i(src_i),
		.imm_i(imm_i), .offset_i(offset_i), .target_i(target_i),
		.rd_addr_i(rd_addr_i), .pc_o(pc_o), .sreg_o(sreg_o), .sp_o(sp_o),
		.busy_o(busy_o), .done_o(done_o), .rd_data_o(rd_data_o));

	// ==========================================
	// Reporting
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_clk(input int got, input int exp);
		check_count++;
		if (got != exp) begin
			fails++;
			$display("ERROR t=%0t clocks got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_clk

	// Hang guard well above the few hundred cycles the run needs
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end

	// ==========================================
	// Drivers
	task automatic do_reset();
		@(negedge core_clk_i);
		reset_i = 1'b1;
		repeat (5) @(negedge core_clk_i);
		reset_i = 1'b0;
		epc = 16'h0000;
	endtask : do_reset

	// Clocks counted from the take edge to the cycle done_o shows
	task automatic run(input cfc_op_type op, input logic [4:0] d,
		input logic [4:0] s, input logic [7:0] k, input logic [11:0] off,
		input logic [15:0] t, input int clk);
		int n;
		@(negedge core_clk_i);
		start_i = 1'b1;
		op_i = op;
		dst_i = d;
		src_i = s;
		imm_i = k;
		offset_i = off;
		target_i = t;
		@(negedge core_clk_i);
		start_i = 1'b0;
		cmp_val({15'h0000, busy_o}, {15'h0000, clk > 1});
		n = 1;
		while (done_o !== 1'b1 && n < 8) begin
			@(negedge core_clk_i);
			n++;
		end
		if (op < op_relative_jump) epc = epc + 16'h0001;
		cmp_clk(n, clk);
		cmp_val(pc_o, epc);
	endtask : run

	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(negedge core_clk_i);
		rd_addr_i = a;
		@(negedge core_clk_i);
		v = rd_data_o;
	endtask : rd

	task automatic ld(input logic [4:0] r, input logic [7:0] v);
		run(op_clear_mask_bits, r, r, 8'hff, 12'h000, 16'h0000, 1);
		run(op_set_mask_bits, r, r, v, 12'h000, 16'h0000, 1);
	endtask : ld

	task automatic chk(input cfc_op_type op, input logic [4:0] d,
		input logic [4:0] s, input logic [7:0] k, input logic [7:0] exp,
		input logic [7:0] fm, input logic [7:0] fe, input int clk);
		logic [7:0] v;
		run(op, d, s, k, 12'h000, 16'h0000, clk);
		rd(d, v);
		cmp_val({8'h00, v}, {8'h00, exp});
		cmp_val({8'h00, sreg_o & fm}, {8'h00, fe});
	endtask : chk

	task automatic flw(input cfc_op_type op, input logic [11:0] off,
		input logic [15:0] t, input logic [15:0] pc, input logic [3:0] sp,
		input logic [7:0] sr, input int clk);
		epc = pc;
		run(op, 5'h00, 5'h00, 8'h00, off, t, clk);
		cmp_val({12'h000, sp_o}, {12'h000, sp});
		cmp_val({8'h00, sreg_o}, {8'h00, sr});
	endtask : flw

	// ==========================================
	// Scenarios
	task automatic test_arith();
		ld(5'h02, 8'h0f);
		ld(5'h03, 8'h01);
		ld(5'h04, 8'hff);
		chk(op_add_registers, 5'h02, 5'h03, 8'h00, 8'h10, 8'h2f, 8'h20, 1);
		chk(op_add_registers, 5'h04, 5'h03, 8'h00, 8'h00, 8'h2f, 8'h23, 1);
		chk(op_add_with_carry, 5'h02, 5'h03, 8'h00, 8'h12, 8'h2f, 8'h00, 1);
		chk(op_subtract_registers, 5'h02, 5'h03, 8'h00, 8'h11, 8'h2f, 8'h00, 1);
		chk(op_subtract_constant, 5'h02, 5'h00, 8'h12, 8'hff, 8'h2f, 8'h25, 1);
		chk(op_subtract_with_borrow, 5'h02, 5'h03, 8'h00, 8'hfd, 8'h2f, 8'h04, 1);
		chk(op_subtract_constant_with_borrow, 5'h02, 5'h00, 8'hfd, 8'h00, 8'h2f,
			8'h02, 1);
	endtask : test_arith

	task automatic test_word();
		logic [7:0] v;
		ld(5'h18, 8'hff);
		ld(5'h19, 8'h00);
		chk(op_word_add_immediate, 5'h18, 5'h00, 8'h01, 8'h00, 8'h1f, 8'h00, 2);
		rd(5'h19, v);
		cmp_val({8'h00, v}, 16'h0001);
		ld(5'h1a, 8'h01);
		ld(5'h1b, 8'h00);
		chk(op_word_subtract_immediate, 5'h1a, 5'h00, 8'h02, 8'hff, 8'h1f, 8'h15,
			2);
		rd(5'h1b, v);
		cmp_val({8'h00, v}, 16'h00ff);
	endtask : test_word

	task automatic test_logic();
		ld(5'h05, 8'hf0);
		ld(5'h06, 8'h3c);
		chk(op_conjunction, 5'h05, 5'h06, 8'h00, 8'h30, 8'h0e, 8'h00, 1);
		chk(op_conjunction_with_constant, 5'h05, 5'h00, 8'h10, 8'h10, 8'h0e, 8'h00,
			1);
		chk(op_disjunction, 5'h05, 5'h06, 8'h00, 8'h3c, 8'h0e, 8'h00, 1);
		chk(op_disjunction_with_constant, 5'h05, 5'h00, 8'h80, 8'hbc, 8'h0e, 8'h04,
			1);
		chk(op_exclusive_disjunction, 5'h05, 5'h06, 8'h00, 8'h80, 8'h0e, 8'h04, 1);
		chk(op_clear_mask_bits, 5'h05, 5'h00, 8'h80, 8'h00, 8'h0e, 8'h02, 1);
		chk(op_set_mask_bits, 5'h05, 5'h00, 8'h81, 8'h81, 8'h0e, 8'h04, 1);
		chk(op_zero_minus_test, 5'h06, 5'h06, 8'h00, 8'h3c, 8'h0e, 8'h00, 1);
	endtask : test_logic

	task automatic test_products();
		logic [7:0] lo;
		logic [7:0] hi;
		ld(5'h07, 8'h80);
		ld(5'h08, 8'h02);
		for (int i = 0; i < 6; i++) begin
			run(pops[i], 5'h07, 5'h08, 8'h00, 12'h000, 16'h0000, 2);
			rd(5'h00, lo);
			rd(5'h01, hi);
			cmp_val({hi, lo}, pexp[i]);
			cmp_val({8'h00, sreg_o & 8'h03}, {8'h00, pfl[i]});
		end
	endtask : test_products

	task automatic test_flow();
		cmp_val(pc_o, 16'h0000);
		cmp_val({12'h000, sp_o}, 16'h000f);
		ld(5'h1e, 8'h34);
		ld(5'h1f, 8'h12);
		flw(op_relative_call, 12'h010, 16'h0000, 16'h0015, 4'he, 8'h00, 3);
		flw(op_indirect_call, 12'h000, 16'h0000, 16'h1234, 4'hd, 8'h00, 3);
		flw(op_relative_jump, 12'hffe, 16'h0000, 16'h1233, 4'hd, 8'h00, 2);
		flw(op_indirect_jump, 12'h000, 16'h0000, 16'h1234, 4'hd, 8'h00, 2);
		flw(op_direct_jump, 12'h000, 16'h0abc, 16'h0abc, 4'hd, 8'h00, 3);
		flw(op_direct_call, 12'h000, 16'h0200, 16'h0200, 4'hc, 8'h00, 4);
		flw(op_subroutine_return, 12'h000, 16'h0000, 16'h0abe, 4'hd, 8'h00, 4);
		flw(op_interrupt_return, 12'h000, 16'h0000, 16'h0016, 4'he, 8'h80, 4);
		flw(op_subroutine_return, 12'h000, 16'h0000, 16'h0005, 4'hf, 8'h80, 4);
	endtask : test_flow

	// ==========================================
	// Main sequence
	initial begin
		do_reset();
		test_arith();
		test_word();
		test_logic();
		test_products();
		do_reset();
		test_flow();
		finish_test();
	end
endmodule : cfc_core_tb
`default_nettype wire
